// [rtl/ebm_pkg.sv]
package ebm_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int BW = 4;
  localparam int SW = 4;
  localparam int CW = 13;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CFG   = 8'h00;
  localparam logic [AW-1:0] OFS_STAT  = 8'h04;
  localparam logic [AW-1:0] OFS_ADDR  = 8'h08;
  localparam logic [AW-1:0] OFS_WDATA = 8'h0C;
  localparam logic [AW-1:0] OFS_CMD   = 8'h10;
  localparam logic [AW-1:0] OFS_RDATA = 8'h14;

  localparam int CMD_WR_BIT  = 0;
  localparam int CMD_BE_LSB  = 4;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_ABORT  = 2;
  localparam int STAT_STATE  = 4;

  localparam logic [CW-1:0] CFG_RST = 13'h0000;
  localparam logic [SW-1:0] CNT_ZERO = 4'h0;
  localparam logic [SW-1:0] CNT_ONE  = 4'h1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic {
    EBM_LATCH  = 1'b0,
    EBM_STROBE = 1'b1
  } ebm_style_t;

  typedef struct packed {
    logic [SW-1:0] istr;
    logic [SW-1:0] dstr;
    logic [SW-1:0] astr;
    ebm_style_t    style;
  } ebm_cfg_t;

  typedef struct packed {
    logic          ale;
    logic          rd_n;
    logic          wr_n;
    logic          as_n;
    logic          ds_n;
    logic          rw;
    logic          grant_acknowledge_n_n;
    logic [BW-1:0] be;
  } ebm_cmd_t;

  localparam ebm_cmd_t CMD_PARK = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, as_n: 1'b1,
                                    ds_n: 1'b1, rw: 1'b1, grant_acknowledge_n_n: 1'b1, be: 4'h0};

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_REQ   = 4'b0001,
    S_CMD   = 4'b0010,
    S_ADDR  = 4'b0011,
    S_ALE   = 4'b0100,
    S_AHOLD = 4'b0101,
    S_DSET  = 4'b0110,
    S_DATA  = 4'b0111,
    S_DHOLD = 4'b1000,
    S_IDLEW = 4'b1001
  } ebm_state_t;
endpackage

// [rtl/ebm_top.sv]
// Function
// - expansion clock halved when halve select high
// - latch style idle bus floats
// - command lines valid one cycle after grant
// - address driven two cycles after grant
// - latch strobe third cycle, address stretch
// - address held one cycle after latch
// - write data precedes write strobe; reads float
// - data stretch; read sampled at strobe rise
// - data and enables held one cycle
// - request dropped, bus parked after strobe
// - command lines float after grant drop
// - grant loss floats bus, no retry
// - latch style idle stretch before request
// - strobe style idle bus floats
// - strobe style command then address timing
// - grant acknowledge three cycles after grant
// - address strobe stretch and address hold
// - read/write and data before data strobe
// - data strobe stretch and read sample
// - strobe style hold after acknowledge drop
// - strobe style request drop and park
// - strobe style idle stretch before request
//
// Local design decisions: the register offsets and strobed register access.
module ebm_top
  import ebm_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  input  wire logic [AW-1:0] reg_addr_in,
  input  wire logic [DW-1:0] reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic      [DW-1:0] reg_rdata_out,
  input  wire logic          clk_halve_select_in,
  output logic               expansion_clock_out,
  input  wire logic          latch_style_bus_grant_in,
  output logic               bus_request_out,
  input  wire logic          strobe_style_grant_n_in,
  output logic               strobe_style_request_n_out,
  input  wire logic [DW-1:0] muxed_addr_data_in,
  output logic      [DW-1:0] muxed_addr_data_out,
  output logic               muxed_addr_data_oe_out,
  output logic      [BW-1:0] byte_lane_enables_out,
  output logic               addr_latch_strobe_out,
  output logic               read_strobe_n_out,
  output logic               write_strobe_n_out,
  output logic               address_strobe_n_out,
  output logic               data_strobe_n_out,
  output logic               read_write_out,
  output logic               grant_acknowledge_n_out,
  output logic               cmd_oe_out
);

  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  function automatic logic is_active(input ebm_state_t s);
    is_active = (s inside {S_CMD, S_ADDR, S_ALE, S_AHOLD, S_DSET, S_DATA, S_DHOLD});
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0]    gl_q, gs_q, hv_q;
  logic [DW-1:0] ad_m_q, ad_s_q;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      gl_q   <= 2'h0;
      gs_q   <= 2'h3;
      hv_q   <= 2'h0;
      ad_m_q <= '0;
      ad_s_q <= '0;
    end else if (ce_in) begin
      gl_q   <= {gl_q[0], latch_style_bus_grant_in};
      gs_q   <= {gs_q[0], strobe_style_grant_n_in};
      hv_q   <= {hv_q[0], clk_halve_select_in};
      ad_m_q <= muxed_addr_data_in;
      ad_s_q <= ad_m_q;
    end
  end

  // ------------------------------------------------------------
  // expansion clock
  // ------------------------------------------------------------
  // bus state moves on each rising expansion clock edge (tick)
  logic expansion_clock_out_q, div_q, step, tick;
  assign step = !hv_q[1] || div_q;
  assign tick = ce_in && step && !expansion_clock_out_q;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      expansion_clock_out_q <= 1'b0;
      div_q  <= 1'b0;
    end else if (ce_in) begin
      div_q <= hv_q[1] ? !div_q : 1'b0;
      if (step) begin
        expansion_clock_out_q <= !expansion_clock_out_q;
      end
    end
  end

  // ------------------------------------------------------------
  // state and events
  // ------------------------------------------------------------
  ebm_state_t    st_q;
  ebm_cfg_t      cfg_q, cur_q;
  logic [SW-1:0] cnt_q;
  logic [BW-1:0] be_q;
  logic [DW-1:0] addr_q, wdata_q, rdata_q;
  logic          go_q, wr_q, done_q, abort_q, parked_q;
  logic          grant, take, abort_evt, done_evt, latch;
  assign latch     = (cur_q.style == EBM_LATCH);
  assign grant     = latch ? gl_q[1] : !gs_q[1];
  assign take      = tick && st_q == S_IDLE && go_q;
  assign abort_evt = tick && is_active(st_q) && !grant;
  assign done_evt  = tick && st_q == S_DATA && cnt_q == CNT_ZERO && grant;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // a start while busy is dropped: software polls busy first
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      cfg_q   <= CFG_RST;
      addr_q  <= '0;
      wdata_q <= '0;
      wr_q    <= 1'b0;
      be_q    <= '0;
      go_q    <= 1'b0;
    end else if (ce_in) begin
      if (take) begin
        go_q <= 1'b0;
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          OFS_CFG:   cfg_q   <= reg_wdata_in[CW-1:0];
          OFS_ADDR:  addr_q  <= reg_wdata_in;
          OFS_WDATA: wdata_q <= reg_wdata_in;
          OFS_CMD: begin
            if (!go_q && st_q == S_IDLE) begin
              wr_q <= reg_wdata_in[CMD_WR_BIT];
              be_q <= reg_wdata_in[CMD_BE_LSB +: BW];
              go_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sticky flags: hardware set beats software clear
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      done_q  <= 1'b0;
      abort_q <= 1'b0;
    end else if (ce_in) begin
      if (done_evt) begin
        done_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == OFS_STAT && reg_wdata_in[STAT_DONE]) begin
        done_q <= 1'b0;
      end
      if (abort_evt) begin
        abort_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == OFS_STAT && reg_wdata_in[STAT_ABORT]) begin
        abort_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (ce_in) begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          OFS_CFG:   reg_rdata_out <= {{(DW-CW){1'b0}}, cfg_q};
          OFS_STAT: begin
            reg_rdata_out[STAT_BUSY]  <= go_q || st_q != S_IDLE;
            reg_rdata_out[STAT_DONE]  <= done_q;
            reg_rdata_out[STAT_ABORT] <= abort_q;
            reg_rdata_out[STAT_STATE +: 4] <= st_q;
          end
          OFS_ADDR:  reg_rdata_out <= addr_q;
          OFS_WDATA: reg_rdata_out <= wdata_q;
          OFS_CMD: begin
            reg_rdata_out[CMD_WR_BIT]       <= wr_q;
            reg_rdata_out[CMD_BE_LSB +: BW] <= be_q;
          end
          OFS_RDATA: reg_rdata_out <= rdata_q;
          default:   reg_rdata_out <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  ebm_cmd_t      cmd_q;
  logic          cmd_oe_q, ad_oe_q, hold_q, br_n_q;
  logic [DW-1:0] ad_q;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st_q     <= S_IDLE;
      cur_q    <= CFG_RST;
      cnt_q    <= CNT_ZERO;
      cmd_q    <= CMD_PARK;
      cmd_oe_q <= 1'b0;
      ad_oe_q  <= 1'b0;
      ad_q     <= '0;
      hold_q   <= 1'b0;
      br_n_q   <= 1'b1;
      parked_q <= 1'b0;
      rdata_q  <= '0;
    end else if (tick) begin
      if (abort_evt) begin
        // grant lost mid-cycle: float all, never retried
        st_q     <= S_IDLEW;
        cnt_q    <= cur_q.istr;
        cmd_q    <= CMD_PARK;
        cmd_oe_q <= 1'b0;
        ad_oe_q  <= 1'b0;
        hold_q   <= 1'b0;
        br_n_q   <= 1'b1;
        parked_q <= 1'b0;
      end else begin
        if (!is_active(st_q) && parked_q && !grant) begin
          cmd_oe_q <= 1'b0;
          parked_q <= 1'b0;
        end
        case (st_q)
          S_IDLE: begin
            if (go_q) begin
              st_q   <= S_REQ;
              cur_q  <= cfg_q;
              hold_q <= (cfg_q.style == EBM_LATCH);
              br_n_q <= (cfg_q.style == EBM_LATCH);
            end
          end
          S_REQ: begin
            if (grant) begin
              st_q     <= S_CMD;
              cmd_oe_q <= 1'b1;
              cmd_q    <= CMD_PARK;
              cmd_q.be <= be_q;
            end
          end
          S_CMD: begin
            st_q    <= S_ADDR;
            ad_oe_q <= 1'b1;
            ad_q    <= addr_q;
          end
          S_ADDR: begin
            st_q          <= S_ALE;
            cnt_q         <= cur_q.astr;
            cmd_q.ale     <= latch;
            cmd_q.grant_acknowledge_n_n <= latch;
          end
          S_ALE: begin
            if (cnt_q == CNT_ZERO) begin
              st_q       <= S_AHOLD;
              cmd_q.ale  <= 1'b0;
              cmd_q.as_n <= latch;
            end else begin
              cnt_q <= cnt_q - CNT_ONE;
            end
          end
          S_AHOLD: begin
            st_q    <= S_DSET;
            ad_oe_q <= wr_q;
            ad_q    <= wdata_q;
            if (!latch) begin
              cmd_q.rw <= !wr_q;
            end
          end
          S_DSET: begin
            st_q  <= S_DATA;
            cnt_q <= cur_q.dstr;
            if (latch) begin
              cmd_q.rd_n <= wr_q;
              cmd_q.wr_n <= !wr_q;
            end else begin
              cmd_q.ds_n <= 1'b0;
            end
          end
          S_DATA: begin
            if (cnt_q == CNT_ZERO) begin
              st_q          <= S_DHOLD;
              cmd_q.rd_n    <= 1'b1;
              cmd_q.wr_n    <= 1'b1;
              cmd_q.ds_n    <= 1'b1;
              cmd_q.grant_acknowledge_n_n <= 1'b1;
              if (!wr_q) begin
                rdata_q <= ad_s_q;
              end
            end else begin
              cnt_q <= cnt_q - CNT_ONE;
            end
          end
          S_DHOLD: begin
            st_q     <= S_IDLEW;
            cnt_q    <= cur_q.istr;
            hold_q   <= 1'b0;
            br_n_q   <= 1'b1;
            ad_oe_q  <= 1'b0;
            cmd_q    <= CMD_PARK;
            parked_q <= 1'b1;
          end
          S_IDLEW: begin
            if (cnt_q == CNT_ZERO) begin
              st_q <= S_IDLE;
            end else begin
              cnt_q <= cnt_q - CNT_ONE;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  assign expansion_clock_out        = expansion_clock_out_q;
  assign bus_request_out            = hold_q;
  assign strobe_style_request_n_out = br_n_q;
  assign muxed_addr_data_out        = ad_q;
  assign muxed_addr_data_oe_out     = ad_oe_q;
  assign byte_lane_enables_out      = cmd_q.be;
  assign addr_latch_strobe_out      = cmd_q.ale;
  assign read_strobe_n_out          = cmd_q.rd_n;
  assign write_strobe_n_out         = cmd_q.wr_n;
  assign address_strobe_n_out       = cmd_q.as_n;
  assign data_strobe_n_out          = cmd_q.ds_n;
  assign read_write_out             = cmd_q.rw;
  assign grant_acknowledge_n_out    = cmd_q.grant_acknowledge_n_n;
  assign cmd_oe_out                 = cmd_oe_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_expansion_clock_out_full_rate: assert property ((ce_in && !hv_q[1]) |=>
    (expansion_clock_out_q != $past(expansion_clock_out_q))) else $error("expansion clock did not toggle");
  a_idle_bus_float: assert property ((st_q == S_IDLE && !parked_q) |->
    (!cmd_oe_q && !ad_oe_q)) else $error("idle bus driven");
  a_cmd_after_grant: assert property ((tick && st_q == S_REQ && grant) |=>
    (st_q == S_CMD && cmd_oe_q && cmd_q.be == be_q)) else $error("command lines late");
  a_addr_after_cmd: assert property ((tick && st_q == S_CMD && grant) |=>
    (ad_oe_q && ad_q == addr_q)) else $error("address not driven");
  a_strobe_third: assert property ((st_q == S_ALE) |->
    (cmd_q.ale == latch && cmd_q.grant_acknowledge_n_n == latch)) else $error("strobe or acknowledge wrong");
  a_addr_hold: assert property ((st_q == S_AHOLD) |->
    (ad_oe_q && ad_q == addr_q && !cmd_q.ale)) else $error("address not held");
  a_write_setup: assert property ((st_q == S_DSET) |->
    (ad_oe_q == wr_q && cmd_q.wr_n && cmd_q.ds_n)) else $error("write data setup wrong");
  a_read_sample: assert property ((done_evt && !wr_q) |=>
    (rdata_q == $past(ad_s_q) && st_q == S_DHOLD)) else $error("read data not sampled");
  a_park_after: assert property ((tick && st_q == S_DHOLD && grant) |=>
    (!hold_q && br_n_q && !ad_oe_q && parked_q)) else $error("bus not parked");
  a_abort_float: assert property (abort_evt |=>
    (!cmd_oe_q && !ad_oe_q && st_q == S_IDLEW && abort_q)) else $error("bus not floated");
endmodule

// [test/ebm_far_model.sv]
module ebm_far_model
  import ebm_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          nrst_in,
  input  wire logic          style_in,
  input  wire logic [3:0]    gdly_in,
  input  wire logic          drop_in,
  input  wire logic [DW-1:0] rd_value_in,
  input  wire logic          xclk_in,
  input  wire logic          req_in,
  input  wire logic          req_n_in,
  input  wire logic          cmd_oe_in,
  input  wire logic          rd_strobe_n_in,
  input  wire logic          data_strobe_n_in,
  input  wire logic          rw_in,
  input  wire logic [DW-1:0] ad_in,
  input  wire logic          ad_oe_in,
  output logic               grant_out,
  output logic               grant_n_out,
  output logic      [DW-1:0] ad_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic          xclk_q;
  logic          g_q;
  logic [3:0]    wait_q;
  logic [DW-1:0] last_q;
  logic          tick;
  logic          req;
  logic          rd_drv;

  // ------------------------------------------------------------
  // arbiter
  // ------------------------------------------------------------
  assign req  = style_in ? ~req_n_in : req_in;
  assign tick = xclk_in & ~xclk_q;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      xclk_q <= 1'b0;
    end else begin
      xclk_q <= xclk_in;
    end
  end

  // grant may come late (gdly ticks) to exercise a slow arbiter
  always_ff @(posedge clock_in) begin
    if (!nrst_in || drop_in) begin
      g_q    <= 1'b0;
      wait_q <= 4'h0;
    end else if (tick) begin
      if (!req) begin
        g_q    <= 1'b0;
        wait_q <= 4'h0;
      end else if (wait_q == gdly_in) begin
        g_q <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end

  assign grant_out   = g_q & ~style_in;
  assign grant_n_out = ~(g_q & style_in);

  // ------------------------------------------------------------
  // peripheral
  // ------------------------------------------------------------
  // released bus flips every cycle so a stale sample never matches
  assign rd_drv = cmd_oe_in & (style_in ? (~data_strobe_n_in & rw_in) : ~rd_strobe_n_in);
  assign ad_out = ad_oe_in ? ad_in : (rd_drv ? rd_value_in : ~last_q);

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      last_q <= '0;
    end else begin
      last_q <= ad_out;
    end
  end
endmodule

// [test/ebm_top_tb.sv]
module ebm_top_tb
  import ebm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic        sel, style, wr;
    logic [3:0]  astr, dstr, istr, gdly, be;
    logic [31:0] addr, data;
  } ebm_row_t;

  logic clock_in, nrst_in, ce_in, reg_wr_in, reg_rd_in, clk_halve_select_in;
  logic [AW-1:0] reg_addr_in;
  logic [DW-1:0] reg_wdata_in, reg_rdata_out, muxed_addr_data_in, muxed_addr_data_out;
  logic expansion_clock_out, latch_style_bus_grant_in, bus_request_out;
  logic strobe_style_grant_n_in, strobe_style_request_n_out, muxed_addr_data_oe_out;
  logic [BW-1:0] byte_lane_enables_out;
  logic addr_latch_strobe_out, read_strobe_n_out, write_strobe_n_out, address_strobe_n_out;
  logic data_strobe_n_out, read_write_out, grant_acknowledge_n_out, cmd_oe_out;
  logic cur_style, drop, eck_prev, cap_rw;
  logic [3:0] gdly, cap_be;
  logic [31:0] rd_value, cap_addr, cap_wd, st;
  int fails, samples_checked, cyc, clk_since, period, a_cnt, d_cnt, n;
  ebm_row_t rows [8];
  ebm_row_t r;

  ebm_top i_ebm_top (.clock_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .clk_halve_select_in, .expansion_clock_out,
    .latch_style_bus_grant_in, .bus_request_out, .strobe_style_grant_n_in,
    .strobe_style_request_n_out, .muxed_addr_data_in, .muxed_addr_data_out,
    .muxed_addr_data_oe_out, .byte_lane_enables_out, .addr_latch_strobe_out,
    .read_strobe_n_out, .write_strobe_n_out, .address_strobe_n_out, .data_strobe_n_out,
    .read_write_out, .grant_acknowledge_n_out, .cmd_oe_out);

  ebm_far_model i_ebm_far_model (.clock_in(clock_in), .nrst_in(nrst_in),
    .style_in(cur_style), .gdly_in(gdly), .drop_in(drop), .rd_value_in(rd_value),
    .xclk_in(expansion_clock_out), .req_in(bus_request_out),
    .req_n_in(strobe_style_request_n_out), .cmd_oe_in(cmd_oe_out),
    .rd_strobe_n_in(read_strobe_n_out), .data_strobe_n_in(data_strobe_n_out),
    .rw_in(read_write_out), .ad_in(muxed_addr_data_out), .ad_oe_in(muxed_addr_data_oe_out),
    .grant_out(latch_style_bus_grant_in), .grant_n_out(strobe_style_grant_n_in),
    .ad_out(muxed_addr_data_in));

  // ------------------------------------------------------------
  // clock, timeout and bus monitor
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: run hung", $time);
      end_sim();
    end
  end

  // samples each expansion cycle mid-clock, once outputs have settled
  always @(negedge clock_in) begin
    clk_since++;
    if (expansion_clock_out && !eck_prev) begin
      period = clk_since;
      clk_since = 0;
      if (cmd_oe_out && (cur_style ? (!grant_acknowledge_n_out && address_strobe_n_out)
                                   : addr_latch_strobe_out)) begin
        a_cnt++;
        cap_addr = muxed_addr_data_out;
      end
      if (cmd_oe_out && (cur_style ? !data_strobe_n_out
                                   : !(read_strobe_n_out && write_strobe_n_out))) begin
        d_cnt++;
        cap_be = byte_lane_enables_out;
        cap_rw = read_write_out;
        if (muxed_addr_data_oe_out) cap_wd = muxed_addr_data_out;
      end
    end
    eck_prev = expansion_clock_out;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    d = reg_rdata_out;
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 400; k++) begin
      reg_read(OFS_STAT, st);
      if (st[STAT_BUSY] === 1'b0) return;
    end
    cmp(st, 32'h0, "still busy");
  endtask

  task automatic end_sim();
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    // sel style wr astr dstr istr gdly be addr data
    rows[0] = '{1, 0, 1, 0, 0, 0, 0, 4'hF, 32'h0000_1000, 32'hA5A5_0F0F};
    rows[1] = '{1, 0, 0, 2, 3, 1, 3, 4'h3, 32'h0000_2004, 32'h1234_5678};
    rows[2] = '{1, 1, 1, 1, 0, 2, 0, 4'hC, 32'h0003_0008, 32'hDEAD_BEEF};
    rows[3] = '{1, 1, 0, 0, 2, 0, 2, 4'h5, 32'h0040_000C, 32'h8765_4321};
    rows[4] = '{0, 0, 1, 15, 15, 15, 1, 4'h1, 32'hFFFF_FFFC, 32'h0000_0001};
    rows[5] = '{0, 1, 0, 0, 1, 0, 0, 4'hF, 32'h0500_0010, 32'hC3C3_3C3C};
    rows[6] = '{0, 1, 1, 3, 4, 1, 2, 4'h8, 32'h6000_0014, 32'h8000_0000};
    rows[7] = '{1, 0, 0, 15, 15, 3, 0, 4'hE, 32'h0000_0018, 32'h0F1E_2D3C};
    nrst_in = 1'b0;
    ce_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    clk_halve_select_in = 1'b1;
    cur_style = 1'b0;
    gdly = 4'h0;
    drop = 1'b0;
    rd_value = 32'h0;
    eck_prev = 1'b0;
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    cmp(reg_rdata_out, 32'h0, "reset rdata");
    cmp({27'h0, cmd_oe_out, muxed_addr_data_oe_out, bus_request_out,
         strobe_style_request_n_out, expansion_clock_out}, 32'h2, "reset pins");
    @(posedge clock_in);
    nrst_in <= 1'b1;
    reg_read(8'h40, st);
    cmp(st, 32'h0, "unmapped read");
    reg_read(OFS_CFG, st);
    cmp(st, {19'h0, CFG_RST}, "cfg reset");
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clock_in);
      cur_style <= r.style;
      clk_halve_select_in <= r.sel;
      gdly <= r.gdly;
      rd_value <= r.data;
      reg_write(OFS_CFG, {19'h0, r.istr, r.dstr, r.astr, r.style});
      reg_write(OFS_ADDR, r.addr);
      reg_write(OFS_WDATA, r.data);
      a_cnt = 0;
      d_cnt = 0;
      cap_wd = 32'h0;
      reg_write(OFS_CMD, {24'h0, r.be, 3'h0, r.wr});
      wait_idle();
      cmp(st & 32'h7, 32'h2, "status after transfer");
      cmp(32'(a_cnt), 32'(r.astr) + 1, "address phase length");
      cmp(32'(d_cnt), 32'(r.dstr) + 1, "strobe low length");
      cmp(cap_addr, r.addr, "address on bus");
      cmp({28'h0, cap_be}, {28'h0, r.be}, "byte lanes");
      cmp(cap_wd, r.wr ? r.data : 32'h0, "write data or released");
      if (r.style) cmp({31'h0, cap_rw}, {31'h0, ~r.wr}, "read write line");
      if (!r.wr) begin
        reg_read(OFS_RDATA, st);
        cmp(st, r.data, "read data");
      end
      cmp(32'(period), r.sel ? 32'h4 : 32'h2, "expansion clock period");
      repeat (40) @(negedge clock_in);
      cmp({28'h0, cmd_oe_out, muxed_addr_data_oe_out, bus_request_out,
           strobe_style_request_n_out}, 32'h1, "bus parked then released");
      reg_write(OFS_STAT, 32'h2);
    end
    // grant withdrawn in the middle of a long address phase
    @(posedge clock_in);
    cur_style <= 1'b0;
    clk_halve_select_in <= 1'b1;
    gdly <= 4'h0;
    reg_write(OFS_CFG, {19'h0, 4'h0, 4'h0, 4'h8, 1'b0});
    a_cnt = 0;
    reg_write(OFS_CMD, 32'h0F0);
    for (n = 0; n < 300 && a_cnt == 0; n++) @(negedge clock_in);
    @(posedge clock_in);
    drop <= 1'b1;
    for (n = 0; n < 30 && (cmd_oe_out || muxed_addr_data_oe_out); n++) @(negedge clock_in);
    cmp(32'(n <= 12), 32'h1, "bus released after grant loss");
    wait_idle();
    cmp(st & 32'h5, 32'h4, "abort flagged");
    @(posedge clock_in);
    drop <= 1'b0;
    n = 0;
    repeat (100) begin
      @(negedge clock_in);
      if (bus_request_out !== 1'b0) n++;
    end
    cmp(32'(n), 32'h0, "no retry");
    @(posedge clock_in);
    ce_in <= 1'b0;
    @(negedge clock_in);
    n = int'(expansion_clock_out);
    repeat (20) @(negedge clock_in);
    cmp({31'h0, expansion_clock_out}, 32'(n), "expansion clock frozen");
    @(posedge clock_in);
    ce_in <= 1'b1;
    reg_write(OFS_STAT, 32'h4);
    end_sim();
  end
endmodule
